// file: common/twcrp_regs.svh
// offsets, field positions, reset values and counts of the serial config port
`ifndef TWCRP_REGS_SVH
`define TWCRP_REGS_SVH
`define TWCRP_AW              8
`define TWCRP_OFF_LATCH_END   8'h40
`define TWCRP_OFF_AFC         8'h40
`define TWCRP_OFF_RSSI        8'h44
`define TWCRP_OFF_ADC         8'h48
`define TWCRP_OFF_FCAL        8'h4c
`define TWCRP_OFF_STAT        8'h50
`define TWCRP_IDX_MSB         5
`define TWCRP_IDX_LSB         2
`define TWCRP_HSIZE_WORD      3'h2
`define TWCRP_NONSEQ_BIT      1
`define TWCRP_SEL_MSB         3
`define TWCRP_SEL_LSB         0
`define TWCRP_RB_LATCH        4'h7
`define TWCRP_RB_EN_BIT       8
`define TWCRP_RB_SRC_LSB      4
`define TWCRP_RB_SRC_W        3
`define TWCRP_RB_MSB          15
`define TWCRP_RB_LAST         4'hf
`define TWCRP_RB_EDGES        5'h12
`define TWCRP_AFC_W           16
`define TWCRP_LVL_W           7
`define TWCRP_GAIN_W          2
`define TWCRP_RSSI_LSB        0
`define TWCRP_FG_LSB          7
`define TWCRP_LG_LSB          9
`define TWCRP_BATT_LSB        0
`define TWCRP_ADCIN_LSB       8
`define TWCRP_TEMP_LSB        16
`define TWCRP_FCAL_W          8
`define TWCRP_STAT_CE         0
`define TWCRP_STAT_BUSY       1
`define TWCRP_STAT_IDX_LSB    4
`define TWCRP_STAT_CNT_LSB    8
`define TWCRP_LATCH_RST       32'h0000_0000
// product and revision codes: arbitrary values
`define TWCRP_PRODUCT_CODE    12'h345
`define TWCRP_REVISION_CODE   4'h2
`endif

// file: common/twcrp_pkg.sv
// types shared by the serial config port
package twcrp_pkg;
  typedef enum logic [1:0] {
    RB_IDLE  = 2'b00,
    RB_ARMED = 2'b01,
    RB_DATA  = 2'b10,
    RB_TAIL  = 2'b11
  } twcrp_rb_state_type;

  typedef enum logic [2:0] {
    SRC_AFC   = 3'b000,
    SRC_RSSI  = 3'b001,
    SRC_BATT  = 3'b010,
    SRC_ADCIN = 3'b011,
    SRC_TEMP  = 3'b100,
    SRC_REV   = 3'b101,
    SRC_FCAL  = 3'b110
  } twcrp_rb_src_type;

  typedef struct packed {
    logic signed [15:0] afc;
    logic [6:0]         rssi;
    logic [1:0]         fgain;
    logic [1:0]         lgain;
    logic [6:0]         batt;
    logic [6:0]         adcin;
    logic [6:0]         temp;
    logic [7:0]         fcal;
  } twcrp_meas_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } twcrp_ahb_phase_type;
endpackage

// file: hw/twcrp_readback.sv
// readback sequencer: dummy bit, sixteen status bits, release of the read pin
`timescale 1ns/10ps
`include "twcrp_regs.svh"
module twcrp_readback (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic        sclk_rise,
  input  wire logic        abort,
  input  wire logic [15:0] word,
  output logic             read_line,
  output logic             read_oe,
  output logic             busy
);
  twcrp_pkg::twcrp_rb_state_type st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [15:0] word_q, word_d;
  logic        line_q, line_d;
  logic        oe_q, oe_d;
  logic [4:0]  edges_q, edges_d;
  logic        msb_w;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    word_d = word_q;
    line_d = line_q;
    oe_d   = oe_q;
    // strobe low or chip off ends any readout at once
    if (abort) begin
      st_d   = twcrp_pkg::RB_IDLE;
      oe_d   = 1'b0;
      line_d = 1'b0;
    end else if (start) begin
      st_d   = twcrp_pkg::RB_ARMED;
      word_d = word;
      cnt_d  = 4'h0;
      oe_d   = 1'b0;
    end else if (sclk_rise) begin
      unique case (st_q)
        twcrp_pkg::RB_IDLE: begin
        end
        twcrp_pkg::RB_ARMED: begin
          oe_d   = 1'b1;
          line_d = 1'b0;
          st_d   = twcrp_pkg::RB_DATA;
        end
        twcrp_pkg::RB_DATA: begin
          line_d = word_q[`TWCRP_RB_MSB];
          word_d = {word_q[`TWCRP_RB_MSB-1:0], 1'b0};
          cnt_d  = cnt_q + 4'h1;
          if (cnt_q == `TWCRP_RB_LAST) begin
            st_d = twcrp_pkg::RB_TAIL;
          end
        end
        twcrp_pkg::RB_TAIL: begin
          oe_d   = 1'b0;
          line_d = 1'b0;
          st_d   = twcrp_pkg::RB_IDLE;
        end
      endcase
    end
  end

  // edge count since start, read only by the checks below
  always_comb begin
    edges_d = edges_q;
    if (start || abort) begin
      edges_d = 5'h00;
    end else if (sclk_rise && busy) begin
      edges_d = edges_q + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= twcrp_pkg::RB_IDLE;
      cnt_q   <= 4'h0;
      word_q  <= 16'h0000;
      line_q  <= 1'b0;
      oe_q    <= 1'b0;
      edges_q <= 5'h00;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      word_q  <= word_d;
      line_q  <= line_d;
      oe_q    <= oe_d;
      edges_q <= edges_d;
    end
  end

  assign read_line = line_q;
  assign read_oe   = oe_q;
  assign busy      = (st_q != twcrp_pkg::RB_IDLE);
  assign msb_w     = word_q[`TWCRP_RB_MSB];

  sequence s_first_data;
    st_q == twcrp_pkg::RB_DATA && cnt_q == 4'h0 && sclk_rise && !abort && !start;
  endsequence

  sequence s_last_edge;
    busy && sclk_rise && !abort && !start && edges_q == `TWCRP_RB_EDGES - 5'h01;
  endsequence

  property p_rb_idle_release;
    @(posedge hclk) disable iff (!hresetn)
      (st_q == twcrp_pkg::RB_IDLE || st_q == twcrp_pkg::RB_ARMED) |-> !read_oe;
  endproperty
  a_rb_idle_release: assert property (p_rb_idle_release)
    else $error("read pin driven outside a readout");

  property p_rb_dummy;
    @(posedge hclk) disable iff (!hresetn)
      (st_q == twcrp_pkg::RB_ARMED && sclk_rise && !abort && !start)
        |=> (read_oe && !read_line && st_q == twcrp_pkg::RB_DATA);
  endproperty
  a_rb_dummy: assert property (p_rb_dummy)
    else $error("dummy bit not driven on first edge");

  property p_rb_msb;
    @(posedge hclk) disable iff (!hresetn)
      s_first_data |=> (read_line == $past(msb_w) && read_oe);
  endproperty
  a_rb_msb: assert property (p_rb_msb)
    else $error("first status bit is not the msb");

  property p_rb_length;
    @(posedge hclk) disable iff (!hresetn)
      s_last_edge |=> (!read_oe && !busy);
  endproperty
  a_rb_length: assert property (p_rb_length)
    else $error("read pin not released on the eighteenth edge");

  property p_rb_abort;
    @(posedge hclk) disable iff (!hresetn)
      abort |=> (!read_oe && !busy);
  endproperty
  a_rb_abort: assert property (p_rb_abort)
    else $error("readout survived a low strobe");
endmodule // twcrp_readback

// file: hw/twcrp_top.sv
// serial config port: shift register, sixteen latches, readback, ahb-lite view
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "twcrp_regs.svh"
module twcrp_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        chip_enable,
  input  wire logic        serial_clock,
  input  wire logic        serial_write_line,
  input  wire logic        load_enable_strobe,
  output logic             serial_read_line,
  output logic             serial_read_oe
);
  logic [31:0] latch_q [16];
  logic [31:0] latch_d [16];
  logic [31:0] shift_q, shift_d;
  logic        sclk_q, le_q;
  logic [3:0]  last_idx_q, last_idx_d;
  logic [7:0]  wcount_q, wcount_d;
  logic [31:0] hrdata_q, hrdata_d;
  twcrp_pkg::twcrp_meas_type      meas_q, meas_d;
  twcrp_pkg::twcrp_ahb_phase_type ph_q, ph_d;
  twcrp_pkg::twcrp_rb_src_type    src_w;
  logic        sclk_rise, le_rise;
  logic        rb_start, rb_abort, rb_busy;
  logic [3:0]  sel_w;
  logic [15:0] status_word;
  logic        accept;

  // pins are sampled on hclk; the serial clock must be well below 5 mhz
  assign sclk_rise = chip_enable && serial_clock && !sclk_q;
  assign le_rise   = chip_enable && load_enable_strobe && !le_q;
  assign sel_w     = shift_q[`TWCRP_SEL_MSB:`TWCRP_SEL_LSB];
  assign src_w     = twcrp_pkg::twcrp_rb_src_type'(
                       shift_q[`TWCRP_RB_SRC_LSB +: `TWCRP_RB_SRC_W]);
  assign rb_start  = le_rise && sel_w == `TWCRP_RB_LATCH
                     && shift_q[`TWCRP_RB_EN_BIT];
  assign rb_abort  = !chip_enable || !load_enable_strobe;

  function automatic logic [15:0] rb_word(
    input twcrp_pkg::twcrp_rb_src_type src,
    input twcrp_pkg::twcrp_meas_type   m
  );
    rb_word = 16'h0000;
    unique case (src)
      twcrp_pkg::SRC_AFC:   rb_word = m.afc;
      twcrp_pkg::SRC_RSSI:  rb_word = {5'h00, m.lgain, m.fgain, m.rssi};
      twcrp_pkg::SRC_BATT:  rb_word = {9'h000, m.batt};
      twcrp_pkg::SRC_ADCIN: rb_word = {9'h000, m.adcin};
      twcrp_pkg::SRC_TEMP:  rb_word = {9'h000, m.temp};
      twcrp_pkg::SRC_REV:   rb_word = {`TWCRP_PRODUCT_CODE, `TWCRP_REVISION_CODE};
      twcrp_pkg::SRC_FCAL:  rb_word = {8'h00, m.fcal};
      default:              rb_word = 16'h0000;
    endcase
  endfunction

  // snapshot taken at the strobe; later measurement writes do not tear it
  assign status_word = rb_word(src_w, meas_q);

  // serial side
  always_comb begin
    shift_d    = shift_q;
    latch_d    = latch_q;
    last_idx_d = last_idx_q;
    wcount_d   = wcount_q;
    // the read pin owns the clock during a readout, write data is not taken
    if (sclk_rise && !rb_busy) begin
      shift_d = {shift_q[30:0], serial_write_line};
    end
    if (le_rise) begin
      latch_d[sel_w] = shift_q;
      last_idx_d     = sel_w;
      wcount_d       = wcount_q + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q    <= `TWCRP_LATCH_RST;
      sclk_q     <= 1'b0;
      le_q       <= 1'b0;
      last_idx_q <= 4'h0;
      wcount_q   <= 8'h00;
      for (int i = 0; i < 16; i++) begin
        latch_q[i] <= `TWCRP_LATCH_RST;
      end
    end else begin
      shift_q    <= shift_d;
      sclk_q     <= serial_clock;
      le_q       <= load_enable_strobe;
      last_idx_q <= last_idx_d;
      wcount_q   <= wcount_d;
      latch_q    <= latch_d;
    end
  end

  twcrp_readback u_readback (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .start     (rb_start),
    .sclk_rise (sclk_rise),
    .abort     (rb_abort),
    .word      (status_word),
    .read_line (serial_read_line),
    .read_oe   (serial_read_oe),
    .busy      (rb_busy)
  );

  // ahb-lite slave, zero wait states, always okay
  assign accept = hsel && hready && htrans[`TWCRP_NONSEQ_BIT]
                  && hsize == `TWCRP_HSIZE_WORD;

  function automatic logic [31:0] rd_mux(input logic [31:0] a);
    logic [31:0] s;
    s = 32'h0000_0000;
    rd_mux = 32'h0000_0000;
    s[`TWCRP_STAT_CE]   = chip_enable;
    s[`TWCRP_STAT_BUSY] = rb_busy;
    s[`TWCRP_STAT_IDX_LSB +: 4] = last_idx_q;
    s[`TWCRP_STAT_CNT_LSB +: 8] = wcount_q;
    if (a[31:`TWCRP_AW] != 24'h000000) begin
      rd_mux = 32'h0000_0000;
    end else if (a[`TWCRP_AW-1:0] < `TWCRP_OFF_LATCH_END) begin
      rd_mux = latch_q[a[`TWCRP_IDX_MSB:`TWCRP_IDX_LSB]];
    end else begin
      case (a[`TWCRP_AW-1:0])
        `TWCRP_OFF_AFC:  rd_mux = {{16{meas_q.afc[15]}}, meas_q.afc};
        `TWCRP_OFF_RSSI: rd_mux = {21'h000000, meas_q.lgain, meas_q.fgain, meas_q.rssi};
        `TWCRP_OFF_ADC:  rd_mux = {9'h000, meas_q.temp, 1'b0, meas_q.adcin,
                                   1'b0, meas_q.batt};
        `TWCRP_OFF_FCAL: rd_mux = {24'h000000, meas_q.fcal};
        `TWCRP_OFF_STAT: rd_mux = s;
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  always_comb begin
    ph_d     = ph_q;
    hrdata_d = hrdata_q;
    meas_d   = meas_q;
    if (hready) begin
      ph_d.valid = accept && haddr[31:`TWCRP_AW] == 24'h000000;
      ph_d.write = hwrite;
      ph_d.addr  = haddr[`TWCRP_AW-1:0];
      if (accept && !hwrite) begin
        hrdata_d = rd_mux(haddr);
      end
    end
    // measurement values stand in for the analog front end's results
    if (ph_q.valid && ph_q.write) begin
      case (ph_q.addr)
        `TWCRP_OFF_AFC: begin
          // unscaled: 100 khz reads as 2^18 * 1e5 / demodulator clock
          meas_d.afc = hwdata[`TWCRP_AFC_W-1:0];
        end
        `TWCRP_OFF_RSSI: begin
          meas_d.rssi  = hwdata[`TWCRP_RSSI_LSB +: `TWCRP_LVL_W];
          meas_d.fgain = hwdata[`TWCRP_FG_LSB +: `TWCRP_GAIN_W];
          meas_d.lgain = hwdata[`TWCRP_LG_LSB +: `TWCRP_GAIN_W];
        end
        `TWCRP_OFF_ADC: begin
          meas_d.batt  = hwdata[`TWCRP_BATT_LSB +: `TWCRP_LVL_W];
          meas_d.adcin = hwdata[`TWCRP_ADCIN_LSB +: `TWCRP_LVL_W];
          meas_d.temp  = hwdata[`TWCRP_TEMP_LSB +: `TWCRP_LVL_W];
        end
        `TWCRP_OFF_FCAL: begin
          meas_d.fcal = hwdata[`TWCRP_FCAL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q     <= '0;
      hrdata_q <= 32'h0000_0000;
      meas_q   <= '0;
    end else begin
      ph_q     <= ph_d;
      hrdata_q <= hrdata_d;
      meas_q   <= meas_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  property p_shift_in;
    @(posedge hclk) disable iff (!hresetn)
      (sclk_rise && !rb_busy) |=> (shift_q[0] == $past(serial_write_line)
        && shift_q[31:1] == $past(shift_q[30:0]));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not shifted in at the lsb");

  property p_ce_ignore;
    @(posedge hclk) disable iff (!hresetn)
      !chip_enable |=> ($stable(shift_q) && $stable(wcount_q));
  endproperty
  a_ce_ignore: assert property (p_ce_ignore)
    else $error("port reacted while chip enable low");

  property p_latch_store;
    @(posedge hclk) disable iff (!hresetn)
      le_rise |=> (latch_q[$past(sel_w)] == $past(shift_q) && last_idx_q == $past(sel_w));
  endproperty
  a_latch_store: assert property (p_latch_store)
    else $error("word not stored in the addressed latch");

  property p_latch_hold;
    @(posedge hclk) disable iff (!hresetn)
      !le_rise |=> $stable(wcount_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch written without a strobe edge");

  property p_rb_start;
    @(posedge hclk) disable iff (!hresetn)
      (rb_start && !rb_abort) |=> (rb_busy && !serial_read_oe);
  endproperty
  a_rb_start: assert property (p_rb_start)
    else $error("readback not armed by the control word");

  property p_rev_word;
    @(posedge hclk) disable iff (!hresetn)
      src_w == twcrp_pkg::SRC_REV
        |-> status_word == {`TWCRP_PRODUCT_CODE, `TWCRP_REVISION_CODE};
  endproperty
  a_rev_word: assert property (p_rev_word)
    else $error("revision word wrong");

  property p_fcal_word;
    @(posedge hclk) disable iff (!hresetn)
      src_w == twcrp_pkg::SRC_FCAL |-> (status_word[15:8] == 8'h00
        && status_word[7:0] == meas_q.fcal);
  endproperty
  a_fcal_word: assert property (p_fcal_word)
    else $error("calibration word wrong");

  property p_rssi_word;
    @(posedge hclk) disable iff (!hresetn)
      src_w == twcrp_pkg::SRC_RSSI |-> (status_word[6:0] == meas_q.rssi
        && status_word[8:7] == meas_q.fgain && status_word[10:9] == meas_q.lgain);
  endproperty
  a_rssi_word: assert property (p_rssi_word)
    else $error("signal strength word misplaced");

  property p_temp_word;
    @(posedge hclk) disable iff (!hresetn)
      src_w == twcrp_pkg::SRC_TEMP |-> status_word == {9'h000, meas_q.temp};
  endproperty
  a_temp_word: assert property (p_temp_word)
    else $error("temperature word wrong");
endmodule // twcrp_top

// file: verification/twcrp_host_model.sv
// host model: drives the three-wire port and reads the status word back
`timescale 1ns/10ps
module twcrp_host_model (
  input  wire logic hclk,
  input  wire logic serial_read_line,
  input  wire logic serial_read_oe,
  output logic      serial_clock,
  output logic      serial_write_line,
  output logic      load_enable_strobe
);
  // each level held 4 hclk, the port needs at least 2
  localparam int half_cycles = 4;

  initial begin
    serial_clock       = 1'b0;
    serial_write_line  = 1'b1;
    load_enable_strobe = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // read pin sampled at the end of the high phase, the host's falling edge
  task automatic pulse(output logic b, output logic oe);
    serial_clock <= 1'b1;
    wait_clk(half_cycles);
    b  = serial_read_line;
    oe = serial_read_oe;
    serial_clock <= 1'b0;
    wait_clk(half_cycles);
  endtask

  task automatic send_word(input logic [31:0] w, input logic keep);
    logic b;
    logic oe;
    load_enable_strobe <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      serial_write_line <= w[i];
      wait_clk(1);
      pulse(b, oe);
    end
    // released data line shows the inverse, not a stale bit
    serial_write_line  <= ~w[0];
    load_enable_strobe <= 1'b1;
    wait_clk(3);
    if (!keep) begin
      load_enable_strobe <= 1'b0;
      wait_clk(2);
    end
  endtask

  // strobe stays high over all 18 clocks, then drops
  task automatic read_status(output logic [15:0] v, output logic junk_oe,
                             output logic data_oe, output logic end_oe);
    logic b;
    logic oe;
    v = 16'h0000;
    pulse(b, junk_oe);
    data_oe = 1'b1;
    for (int i = 0; i < 16; i++) begin
      pulse(b, oe);
      v       = {v[14:0], b};
      data_oe = data_oe & oe;
    end
    pulse(b, oe);
    end_oe = serial_read_oe;
    load_enable_strobe <= 1'b0;
    wait_clk(2);
  endtask
endmodule // twcrp_host_model

// file: verification/twcrp_tb_top.sv
// self-checking bench: ahb register view plus serial writes and readbacks
`timescale 1ns/10ps
`include "twcrp_regs.svh"
`define TWCRP_CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module twcrp_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        chip_enable;
  logic        serial_clock;
  logic        serial_write_line;
  logic        load_enable_strobe;
  logic        serial_read_line;
  logic        serial_read_oe;
  int          n_fail;
  int          compares;

  twcrp_top dut (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .hrdata             (hrdata),
    .chip_enable        (chip_enable),
    .serial_clock       (serial_clock),
    .serial_write_line  (serial_write_line),
    .load_enable_strobe (load_enable_strobe),
    .serial_read_line   (serial_read_line),
    .serial_read_oe     (serial_read_oe)
  );

  twcrp_host_model host (
    .hclk               (hclk),
    .serial_read_line   (serial_read_line),
    .serial_read_oe     (serial_read_oe),
    .serial_clock       (serial_clock),
    .serial_write_line  (serial_write_line),
    .load_enable_strobe (load_enable_strobe)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one single word transfer; waits on hready, read data taken at data-phase end
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= `TWCRP_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  initial begin
    #5_000_000;
    n_fail++;
    test_done();
  end

  initial begin
    logic [31:0] q;
    logic [31:0] words [3];
    logic [15:0] v;
    logic [15:0] exp_v [8];
    logic [15:0] mask  [8];
    logic [7:0]  adj;
    logic        joe;
    logic        doe;
    logic        eoe;
    n_fail      = 0;
    compares    = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0000_0000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = `TWCRP_HSIZE_WORD;
    hwdata      = 32'h0000_0000;
    chip_enable = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_003c, 32'h0, q);
    `TWCRP_CHK(q, 32'h0000_0000)
    `TWCRP_CHK({hreadyout, hresp}, 2'b10)
    // boundary latches 0 and 15 plus a middle one
    words = '{32'h1234_5670, 32'h0a5c_3c85, 32'hdead_beef};
    foreach (words[i]) begin
      host.send_word(words[i], 1'b0);
      ahb(1'b0, {26'h0, words[i][3:0], 2'b00}, 32'h0, q);
      `TWCRP_CHK(q, words[i])
    end
    // port unpowered: word aimed at latch 3 must vanish
    chip_enable <= 1'b0;
    host.send_word(32'h5555_aaa3, 1'b0);
    chip_enable <= 1'b1;
    ahb(1'b0, 32'h0000_000c, 32'h0, q);
    `TWCRP_CHK(q, 32'h0000_0000)
    ahb(1'b0, 32'h0000_0100, 32'h0, q);
    `TWCRP_CHK(q, 32'h0000_0000)
    // latch 7 without the enable bit starts nothing
    host.send_word(32'h0000_0077, 1'b1);
    host.read_status(v, joe, doe, eoe);
    `TWCRP_CHK(joe, 1'b0)
    ahb(1'b1, {24'h000000, `TWCRP_OFF_AFC}, 32'h0000_8123, q);
    ahb(1'b1, {24'h000000, `TWCRP_OFF_RSSI}, 32'h0000_05a5, q);
    ahb(1'b1, {24'h000000, `TWCRP_OFF_ADC}, 32'h0063_2a55, q);
    ahb(1'b1, {24'h000000, `TWCRP_OFF_FCAL}, 32'h0000_00c7, q);
    ahb(1'b0, {24'h000000, `TWCRP_OFF_AFC}, 32'h0, q);
    `TWCRP_CHK(q, 32'hffff_8123)
    // don't-care upper bits masked off
    exp_v = '{16'h8123, 16'h05a5, 16'h0055, 16'h002a, 16'h0063,
              {`TWCRP_PRODUCT_CODE, `TWCRP_REVISION_CODE}, 16'h00c7, 16'h0000};
    mask  = '{16'hffff, 16'h07ff, 16'h007f, 16'h007f, 16'h007f,
              16'hffff, 16'hffff, 16'hffff};
    for (int s = 0; s < 8; s++) begin
      host.send_word(32'h0000_0107 | (s << 4), 1'b1);
      host.read_status(v, joe, doe, eoe);
      `TWCRP_CHK(v & mask[s], exp_v[s])
      `TWCRP_CHK(joe, 1'b1)
      `TWCRP_CHK(doe, 1'b1)
      `TWCRP_CHK(eoe, 1'b0)
    end
    // trim taken from the expected calibration reading, so the check is independent
    adj = exp_v[6][7:0] - 8'h80;
    // manual filter trim goes to latch 5, six-bit field at bits 19:14
    host.send_word({12'h000, adj[5:0], 10'h000, 4'h5}, 1'b0);
    ahb(1'b0, 32'h0000_0014, 32'h0, q);
    `TWCRP_CHK(q, {12'h000, adj[5:0], 10'h000, 4'h5})
    // thirteen latch writes with chip enable high, last one to latch 5, idle
    ahb(1'b0, {24'h000000, `TWCRP_OFF_STAT}, 32'h0, q);
    `TWCRP_CHK(q, 32'h0000_0d51)
    test_done();
  end
endmodule // twcrp_tb_top
